// ===== hw/fsmh_params.svh
`ifndef FSMH_PARAMS_SVH
`define FSMH_PARAMS_SVH

// ----------------------------------------
// Object addresses (index, subindex)
// ----------------------------------------
`define FSMH_IDX_PRIM_WORD 16'h2601
`define FSMH_IDX_SEC_WORD 16'h2602
`define FSMH_IDX_MASKS 16'h2605
`define FSMH_IDX_HIST 16'h2604
`define FSMH_SUB_WORD 8'h00
`define FSMH_SUB_PRIM_IGNORE 8'h01
`define FSMH_SUB_PRIM_STORE_ON 8'h02
`define FSMH_SUB_PRIM_STORE_OFF 8'h03
`define FSMH_SUB_SEC_IGNORE 8'h04
`define FSMH_SUB_SEC_STORE_ON 8'h05
`define FSMH_SUB_SEC_STORE_OFF 8'h06
`define FSMH_SUB_EXT_WORD 8'h07
`define FSMH_SUB_HIST_COUNT 8'h00

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FSMH_RST_WORD 16'h0000
`define FSMH_RST_PRIM_IGNORE 16'hffff
`define FSMH_RST_PRIM_STORE_ON 16'hfbff
`define FSMH_RST_PRIM_STORE_OFF 16'h0000
`define FSMH_RST_SEC_IGNORE 16'hffff
`define FSMH_RST_SEC_STORE_ON 16'hf1ff
`define FSMH_RST_SEC_STORE_OFF 16'h003f

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FSMH_P_SUMMARY 0
`define FSMH_P_ENC_COMM 3
`define FSMH_P_HEATSINK 4
`define FSMH_P_SHORT 7
`define FSMH_P_FOLLOW 9
`define FSMH_P_OVERFREQ 12
`define FSMH_P_ENC_ABSENT 14
`define FSMH_P_NV_SUM 15
`define FSMH_S_CUR_SENSOR 0
`define FSMH_S_WATCHDOG 1
`define FSMH_S_PERMIT 8
`define FSMH_S_POS_LIMIT 9
`define FSMH_S_NEG_LIMIT 10
`define FSMH_S_LINK_LOST 12
`define FSMH_E_PHASE_LOSS 3
`define FSMH_E_SVC_TIMEOUT 12

// ----------------------------------------
// Settings that arm gated faults
// ----------------------------------------
`define FSMH_LIMIT_MODE_FAULT 16'h0000
`define FSMH_LINK_MODE_FAULT 16'h0001

// ----------------------------------------
// Fault codes, bit 15 first
// ----------------------------------------
`define FSMH_PRIM_CODES {16'h6310, 16'h7331, 16'h4310, 16'h8a80, 16'h2350, 16'h5112, 16'h8611, 16'h7110, \
  16'h2320, 16'h3220, 16'h3210, 16'h4210, 16'h7330, 16'h7320, 16'h7331, 16'h0000}
`define FSMH_SEC_CODES {16'h7306, 16'h7382, 16'h8a81, 16'h8100, 16'h6012, 16'h5441, 16'h5442, 16'h5443, \
  16'h0000, 16'h0000, 16'h0000, 16'h6320, 16'h7400, 16'h6011, 16'h6010, 16'h5210}
`define FSMH_EXT_CODES {16'h0000, 16'h0000, 16'h0000, 16'h81ff, 16'h0000, 16'h0000, 16'h0000, 16'h0000, \
  16'h0000, 16'h0000, 16'h0000, 16'h2321, 16'h6321, 16'h7112, 16'h7111, 16'h5210}

`endif

// ===== hw/fsmh_pkg.sv
package fsmh_pkg;

  // Raw detector levels, one per fault bit position
  typedef struct packed {
    logic [15:0] prim;
    logic [15:0] sec;
    logic [15:0] ext;
  } fsmh_det_s;

  // Drive state and settings held elsewhere in the drive
  typedef struct packed {
    logic stage_en;
    logic stage_enabling;
    logic permit_cfg;
    logic permit_active;
    logic [15:0] limit_mode;
    logic [15:0] link_mode;
  } fsmh_ctl_s;

  // Operating snapshot taken with each history entry
  typedef struct packed {
    logic [15:0] bus_volt;
    logic [15:0] speed;
    logic [15:0] current;
    logic [15:0] temp;
    logic [7:0] op_mode;
    logic [7:0] switch_state;
  } fsmh_snap_s;

  typedef struct packed {
    logic [15:0] code;
    logic [15:0] prim;
    logic [15:0] sec;
    fsmh_snap_s snap;
  } fsmh_hist_s;

  typedef struct packed {
    logic req;
    logic wr;
    logic [15:0] index;
    logic [7:0] sub;
    logic [15:0] wdata;
  } fsmh_obj_req_s;

  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
  } fsmh_obj_rsp_s;

endpackage

// ===== hw/fsmh_top.sv
`include "fsmh_params.svh"
`timescale 1ns/1ps
`default_nettype none

module fsmh_top #(
  parameter int HIST_DEPTH = 8
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Fault detectors and drive state
  input wire fsmh_pkg::fsmh_det_s i_det,
  input wire fsmh_pkg::fsmh_ctl_s i_ctl,
  input wire fsmh_pkg::fsmh_snap_s i_snap,
  input wire logic i_fault_clear,
  // Parameter object port
  input wire fsmh_pkg::fsmh_obj_req_s i_obj,
  output var fsmh_pkg::fsmh_obj_rsp_s o_obj,
  // Fault state
  output logic [15:0] o_prim_word,
  output logic [15:0] o_sec_word,
  output logic [15:0] o_ext_word,
  output logic [15:0] o_fault_code,
  output logic o_fault_any,
  // History
  output var fsmh_pkg::fsmh_hist_s [HIST_DEPTH-1:0] o_hist,
  output logic [7:0] o_hist_count
);
  import fsmh_pkg::*;

  localparam logic [255:0] PRIM_CODES = `FSMH_PRIM_CODES;
  localparam logic [255:0] SEC_CODES = `FSMH_SEC_CODES;
  localparam logic [255:0] EXT_CODES = `FSMH_EXT_CODES;

  // ----------------------------------------
  // Mask registers
  // ----------------------------------------
  logic [15:0] pign_ff;
  logic [15:0] pon_ff;
  logic [15:0] poff_ff;
  logic [15:0] sign_ff;
  logic [15:0] son_ff;
  logic [15:0] soff_ff;
  logic wr_mask;

  assign wr_mask = i_obj.req && i_obj.wr && (i_obj.index == `FSMH_IDX_MASKS);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pign_ff <= `FSMH_RST_PRIM_IGNORE;
      pon_ff <= `FSMH_RST_PRIM_STORE_ON;
      poff_ff <= `FSMH_RST_PRIM_STORE_OFF;
      sign_ff <= `FSMH_RST_SEC_IGNORE;
      son_ff <= `FSMH_RST_SEC_STORE_ON;
      soff_ff <= `FSMH_RST_SEC_STORE_OFF;
    end else if (wr_mask) begin
      unique case (i_obj.sub)
        `FSMH_SUB_PRIM_IGNORE: pign_ff <= i_obj.wdata;
        `FSMH_SUB_PRIM_STORE_ON: pon_ff <= i_obj.wdata;
        `FSMH_SUB_PRIM_STORE_OFF: poff_ff <= i_obj.wdata;
        `FSMH_SUB_SEC_IGNORE: sign_ff <= i_obj.wdata;
        `FSMH_SUB_SEC_STORE_ON: son_ff <= i_obj.wdata;
        `FSMH_SUB_SEC_STORE_OFF: soff_ff <= i_obj.wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Fault conditions
  // ----------------------------------------
  // Qualified conditions replace the raw detector bit and the summary bit starts clear; the rest map one to one.
  logic [15:0] prim_cond;
  logic [15:0] sec_cond;
  logic [15:0] ext_cond;

  always_comb begin
    prim_cond = i_det.prim;
    prim_cond[`FSMH_P_SUMMARY] = 1'b0;
    sec_cond = i_det.sec;
    sec_cond[`FSMH_S_PERMIT] = i_ctl.permit_cfg && !i_ctl.permit_active
      && (i_ctl.stage_en || i_ctl.stage_enabling);
    sec_cond[`FSMH_S_POS_LIMIT] = i_det.sec[`FSMH_S_POS_LIMIT]
      && (i_ctl.limit_mode == `FSMH_LIMIT_MODE_FAULT);
    sec_cond[`FSMH_S_NEG_LIMIT] = i_det.sec[`FSMH_S_NEG_LIMIT]
      && (i_ctl.limit_mode == `FSMH_LIMIT_MODE_FAULT);
    sec_cond[`FSMH_S_LINK_LOST] = i_det.sec[`FSMH_S_LINK_LOST]
      && (i_ctl.link_mode == `FSMH_LINK_MODE_FAULT);
    ext_cond = i_det.ext;
  end

  // ----------------------------------------
  // Fault words
  // ----------------------------------------
  // Faults latch until cleared; a fault still present during the clear sets again.
  logic [15:0] prim_ff;
  logic [15:0] sec_ff;
  logic [15:0] ext_ff;
  logic [15:0] nxt_prim;
  logic [15:0] nxt_sec;
  logic [15:0] nxt_ext;
  logic [15:0] new_prim;
  logic [15:0] new_sec;
  logic [15:0] new_ext;

  always_comb begin
    nxt_prim = ((prim_ff & ~{16{i_fault_clear}}) | (prim_cond & pign_ff)) & pign_ff;
    nxt_sec = ((sec_ff & ~{16{i_fault_clear}}) | (sec_cond & sign_ff)) & sign_ff;
    nxt_ext = (ext_ff & ~{16{i_fault_clear}}) | ext_cond;
    nxt_prim[`FSMH_P_SUMMARY] = |nxt_sec;
    new_prim = nxt_prim & ~prim_ff;
    new_prim[`FSMH_P_SUMMARY] = 1'b0;
    new_sec = nxt_sec & ~sec_ff;
    new_ext = nxt_ext & ~ext_ff;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prim_ff <= `FSMH_RST_WORD;
      sec_ff <= `FSMH_RST_WORD;
      ext_ff <= `FSMH_RST_WORD;
    end else begin
      prim_ff <= nxt_prim;
      sec_ff <= nxt_sec;
      ext_ff <= nxt_ext;
    end
  end

  // ----------------------------------------
  // Code of the newest fault
  // ----------------------------------------
  // Several faults in one cycle report the lowest bit, primary before secondary.
  function automatic logic [15:0] first_code(input logic [15:0] bits, input logic [255:0] table_v);
    logic [15:0] code;
    code = 16'h0000;
    for (int b = 15; b >= 0; b--) begin
      if (bits[b]) begin
        code = table_v[b*16 +: 16];
      end
    end
    return code;
  endfunction

  logic [15:0] code_ff;
  logic [15:0] nxt_code;

  always_comb begin
    if (|new_prim) begin
      nxt_code = first_code(new_prim, PRIM_CODES);
    end else if (|new_sec) begin
      nxt_code = first_code(new_sec, SEC_CODES);
    end else if (|new_ext) begin
      nxt_code = first_code(new_ext, EXT_CODES);
    end else begin
      nxt_code = code_ff;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      code_ff <= `FSMH_RST_WORD;
    end else begin
      code_ff <= nxt_code;
    end
  end

  // ----------------------------------------
  // History
  // ----------------------------------------
  // Extension faults never reach the history; only the two masked words are stored.
  logic [15:0] pstore;
  logic [15:0] sstore;
  logic [15:0] store_prim;
  logic [15:0] store_sec;
  logic hist_wr;
  logic [15:0] hist_code;
  fsmh_hist_s [HIST_DEPTH-1:0] hist_ff;
  logic [7:0] count_ff;

  always_comb begin
    pstore = i_ctl.stage_en ? pon_ff : poff_ff;
    sstore = i_ctl.stage_en ? son_ff : soff_ff;
    store_prim = new_prim & pstore;
    store_sec = new_sec & sstore;
    hist_wr = |{store_prim, store_sec};
    hist_code = (|store_prim) ? first_code(store_prim, PRIM_CODES) : first_code(store_sec, SEC_CODES);
  end

  // One entry per cycle at most; faults that arrive together share the entry.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hist_ff[0] <= '0;
    end else if (hist_wr) begin
      hist_ff[0] <= '{code: hist_code, prim: nxt_prim, sec: nxt_sec, snap: i_snap};
    end
  end

  for (genvar g = 1; g < HIST_DEPTH; g++) begin : g_hist
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        hist_ff[g] <= '0;
      end else if (hist_wr) begin
        hist_ff[g] <= hist_ff[g-1];
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_ff <= 8'h00;
    end else if (hist_wr && (count_ff < 8'(HIST_DEPTH))) begin
      count_ff <= count_ff + 8'h01;
    end
  end

  // ----------------------------------------
  // Object read port
  // ----------------------------------------
  // Answer is registered so rdata never glitches; back-to-back requests each get an answer.
  fsmh_obj_rsp_s rsp_ff;
  fsmh_obj_rsp_s nxt_rsp;

  always_comb begin
    nxt_rsp = '{ack: i_obj.req, err: 1'b0, rdata: 16'h0000};
    if (i_obj.req) begin
      if ((i_obj.index == `FSMH_IDX_PRIM_WORD) && (i_obj.sub == `FSMH_SUB_WORD)) begin
        nxt_rsp.rdata = prim_ff;
        nxt_rsp.err = i_obj.wr;
      end else if ((i_obj.index == `FSMH_IDX_SEC_WORD) && (i_obj.sub == `FSMH_SUB_WORD)) begin
        nxt_rsp.rdata = sec_ff;
        nxt_rsp.err = i_obj.wr;
      end else if ((i_obj.index == `FSMH_IDX_HIST) && (i_obj.sub == `FSMH_SUB_HIST_COUNT)) begin
        nxt_rsp.rdata = {8'h00, count_ff};
        nxt_rsp.err = i_obj.wr;
      end else if (i_obj.index == `FSMH_IDX_MASKS) begin
        unique case (i_obj.sub)
          `FSMH_SUB_PRIM_IGNORE: nxt_rsp.rdata = pign_ff;
          `FSMH_SUB_PRIM_STORE_ON: nxt_rsp.rdata = pon_ff;
          `FSMH_SUB_PRIM_STORE_OFF: nxt_rsp.rdata = poff_ff;
          `FSMH_SUB_SEC_IGNORE: nxt_rsp.rdata = sign_ff;
          `FSMH_SUB_SEC_STORE_ON: nxt_rsp.rdata = son_ff;
          `FSMH_SUB_SEC_STORE_OFF: nxt_rsp.rdata = soff_ff;
          `FSMH_SUB_EXT_WORD: begin
            nxt_rsp.rdata = ext_ff;
            nxt_rsp.err = i_obj.wr;
          end
          default: nxt_rsp.err = 1'b1;
        endcase
      end else begin
        nxt_rsp.err = 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff <= nxt_rsp;
    end
  end

  assign o_obj = rsp_ff;
  assign o_prim_word = prim_ff;
  assign o_sec_word = sec_ff;
  assign o_ext_word = ext_ff;
  assign o_fault_code = code_ff;
  assign o_fault_any = |{prim_ff, ext_ff};
  assign o_hist = hist_ff;
  assign o_hist_count = count_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_lone_prim(int b);
    (new_prim == (16'h0001 << b)) && !i_fault_clear;
  endsequence

  sequence s_lone_sec(int b);
    (new_sec == (16'h0001 << b)) && (new_prim == 16'h0000) && !i_fault_clear;
  endsequence

  sequence s_lone_ext(int b);
    (new_ext == (16'h0001 << b)) && (new_prim == 16'h0000) && (new_sec == 16'h0000);
  endsequence

  // Properties other than a_summary_bit and a_count_sat look one edge after the condition, when the registered words have settled.

  a_short_code: assert property (s_lone_prim(7) |=> prim_ff[7] && (code_ff == 16'h2320))
    else $error("short circuit not reported");
  a_heatsink_code: assert property (s_lone_prim(4) |=> prim_ff[4] && (code_ff == 16'h4210))
    else $error("heatsink fault not reported");
  a_follow_set: assert property (i_det.prim[9] && pign_ff[9] |=> prim_ff[9])
    else $error("following fault not latched");
  a_overfreq_code: assert property (s_lone_prim(12) |=> code_ff == 16'h8a80)
    else $error("overfrequency code wrong");
  a_nv_sum_set: assert property (i_det.prim[15] && pign_ff[15] |=> prim_ff[15])
    else $error("checksum fault not latched");
  a_enc_comm_set: assert property (i_det.prim[3] && pign_ff[3] |=> prim_ff[3])
    else $error("encoder comm fault not latched");
  a_enc_absent_set: assert property (i_det.prim[14] && pign_ff[14] |=> prim_ff[14])
    else $error("encoder absent fault not latched");
  a_summary_bit: assert property ($stable(sign_ff) |-> prim_ff[0] == |sec_ff)
    else $error("summary bit disagrees with secondary word");
  a_permit_fault: assert property (i_ctl.permit_cfg && !i_ctl.permit_active && i_ctl.stage_en
    && sign_ff[8] |=> sec_ff[8])
    else $error("permit fault missed");
  a_permit_enabling: assert property (i_ctl.permit_cfg && !i_ctl.permit_active && i_ctl.stage_enabling
    && sign_ff[8] |=> sec_ff[8])
    else $error("permit fault missed while enabling");
  a_pos_limit_gate: assert property ((i_ctl.limit_mode != 16'h0000) && !sec_ff[9] |=> !sec_ff[9])
    else $error("limit fault set while limit setting nonzero");
  a_neg_limit_gate: assert property ((i_ctl.limit_mode != 16'h0000) && !sec_ff[10] |=> !sec_ff[10])
    else $error("negative limit fault set while limit setting nonzero");
  a_link_gate: assert property ((i_ctl.link_mode != 16'h0001) && !sec_ff[12] |=> !sec_ff[12])
    else $error("link fault set in wrong mode");
  a_ignore_prim: assert property (!pign_ff[7] |=> !prim_ff[7])
    else $error("ignored primary fault visible");
  a_store_off: assert property (!i_ctl.stage_en && (poff_ff == 16'h0000) && (soff_ff == 16'h0000)
    |=> $stable(hist_ff[0]))
    else $error("history written with disabled store masks clear");
  a_hist_shift: assert property (hist_wr |=> (hist_ff[1] == $past(hist_ff[0]))
    && (hist_ff[0].snap == $past(i_snap)))
    else $error("history did not shift");
  a_summary_set: assert property (|(sec_cond & sign_ff) |=> prim_ff[0])
    else $error("summary bit missing for unmasked secondary fault");
  a_cur_sensor_set: assert property (i_det.sec[0] && sign_ff[0] |=> sec_ff[0])
    else $error("current sensor fault not latched");
  a_watchdog_code: assert property (s_lone_sec(1) |=> sec_ff[1] && (code_ff == 16'h6010))
    else $error("watchdog fault not reported");
  a_phase_loss_code: assert property (s_lone_ext(3) |=> ext_ff[3] && (code_ff == 16'h6321))
    else $error("phase loss fault not reported");
  a_svc_timeout_set: assert property (i_det.ext[12] |=> ext_ff[12])
    else $error("service timeout fault not latched");
  a_ignore_sec: assert property (!sign_ff[0] |=> !sec_ff[0])
    else $error("ignored secondary fault visible");
  a_store_on_skip: assert property (i_ctl.stage_en && ((new_prim & pon_ff) == 16'h0000)
    && ((new_sec & son_ff) == 16'h0000) |=> $stable(hist_ff[0]))
    else $error("history written for a fault outside the enabled store masks");
  a_store_off_rec: assert property (!i_ctl.stage_en && |(new_sec & soff_ff)
    |=> (hist_ff[0].sec == sec_ff) && (count_ff != 8'h00))
    else $error("stored secondary fault missing from history");
  a_count_sat: assert property (count_ff <= 8'(HIST_DEPTH))
    else $error("history count beyond depth");

endmodule

`default_nettype wire

// ===== tb/fsmh_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module fsmh_host_model (
  // Clock
  input wire logic i_core_clk,
  // Object port
  output var fsmh_pkg::fsmh_obj_req_s o_obj,
  input wire fsmh_pkg::fsmh_obj_rsp_s i_obj
);
  import fsmh_pkg::*;

  initial begin
    o_obj = '0;
  end

  // -----------------------------
  // One object access
  // -----------------------------
  // Strobe lasts one cycle; the answer is due exactly one edge later, so a late ack fails
  task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [15:0] wd,
                        output logic [15:0] rd, output logic err, output logic ok);
    rd = 16'h0000;
    err = 1'b0;
    ok = 1'b0;
    o_obj.req = 1'b1;
    o_obj.wr = wr;
    o_obj.index = idx;
    o_obj.sub = sub;
    o_obj.wdata = wd;
    @(negedge i_core_clk);
    o_obj.req = 1'b0;
    if (i_obj.ack === 1'b1) begin
      rd = i_obj.rdata;
      err = i_obj.err;
      ok = 1'b1;
    end
    @(negedge i_core_clk);
  endtask
endmodule

`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  import fsmh_pkg::*;

  localparam int DEPTH = 8;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clr = 1'b0;
  fsmh_det_s det = '0;
  fsmh_ctl_s ctl = '{1'b1, 1'b0, 1'b1, 1'b1, 16'h0000, 16'h0001};
  fsmh_snap_s snap = '{16'h0123, 16'h0456, 16'h0789, 16'h0abc, 8'h05, 8'h01};
  fsmh_obj_req_s req;
  fsmh_obj_rsp_s rsp;
  logic [15:0] prim_word;
  logic [15:0] sec_word;
  logic [15:0] ext_word;
  logic [15:0] fault_code;
  logic fault_any;
  fsmh_hist_s [DEPTH-1:0] hist;
  logic [7:0] hist_count;
  int n_errors = 0;
  int tests_run = 0;
  int exp_cnt = 0;
  logic [15:0] last = 16'h0000;
  logic [15:0] prv = 16'h0000;

  always #5 clk = ~clk;

  fsmh_top #(.HIST_DEPTH(DEPTH)) i_dut (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_det(det), .i_ctl(ctl), .i_snap(snap), .i_fault_clear(clr),
    .i_obj(req), .o_obj(rsp), .o_prim_word(prim_word), .o_sec_word(sec_word), .o_ext_word(ext_word),
    .o_fault_code(fault_code), .o_fault_any(fault_any), .o_hist(hist), .o_hist_count(hist_count)
  );

  fsmh_host_model i_host (.i_core_clk(clk), .o_obj(req), .i_obj(rsp));

  // -----------------------------
  // Helpers
  // -----------------------------
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("Checks %0d, errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic obj(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [15:0] wd,
                     input logic [15:0] exp, input logic experr);
    logic [15:0] rd;
    logic err;
    logic ok;
    i_host.access(wr, idx, sub, wd, rd, err, ok);
    if (ok !== 1'b1) begin
      n_errors++;
      conclude();
    end
    chk(err, experr);
    if (!wr)
      chk(rd, exp);
  endtask

  // Raise one fault, check words, code and history, then clear it
  task automatic fire(input int k, input int b, input logic [15:0] c, input logic st);
    logic [15:0] m;
    m = 16'h0001 << b;
    if (k == 0)
      det.prim = m;
    else if (k == 2)
      det.ext = m;
    else if (b == 8)
      ctl.permit_active = 1'b0;
    else
      det.sec = m;
    @(negedge clk);
    chk(prim_word, (k == 0) ? m : ((k == 1) ? 16'h0001 : 16'h0000));
    chk(sec_word, (k == 1) ? m : 16'h0000);
    chk(ext_word, (k == 2) ? m : 16'h0000);
    chk(fault_code, c);
    chk(fault_any, 1'b1);
    if (st) begin
      if (exp_cnt < DEPTH)
        exp_cnt++;
      prv = last;
      last = c;
    end
    chk(hist_count, 8'(exp_cnt));
    if (exp_cnt > 0)
      chk(hist[0].code, last);
    if (st && exp_cnt > 1)
      chk(hist[1].code, prv);
    if (st) begin
      chk(hist[0].snap, snap);
      chk(hist[0].prim, (k == 0) ? m : 16'h0001);
      chk(hist[0].sec, (k == 1) ? m : 16'h0000);
    end
    det = '0;
    ctl.permit_active = 1'b1;
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    chk(prim_word | sec_word | ext_word, 16'h0000);
    chk(fault_any, 1'b0);
  endtask

  // Present a condition that must leave every word clear and nothing stored
  task automatic quiet(input logic [15:0] s, input logic [15:0] p);
    det.sec = s;
    det.prim = p;
    @(negedge clk);
    chk(prim_word, 16'h0000);
    chk(sec_word, 16'h0000);
    chk(hist_count, 8'(exp_cnt));
    chk(fault_any, 1'b0);
    det = '0;
    @(negedge clk);
  endtask

  // -----------------------------
  // Sequence
  // -----------------------------
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    obj(1'b0, 16'h2605, 8'h01, 16'h0000, 16'hffff, 1'b0);
    obj(1'b0, 16'h2605, 8'h02, 16'h0000, 16'hfbff, 1'b0);
    obj(1'b0, 16'h2605, 8'h03, 16'h0000, 16'h0000, 1'b0);
    obj(1'b0, 16'h2605, 8'h04, 16'h0000, 16'hffff, 1'b0);
    obj(1'b0, 16'h2605, 8'h05, 16'h0000, 16'hf1ff, 1'b0);
    obj(1'b0, 16'h2605, 8'h06, 16'h0000, 16'h003f, 1'b0);
    obj(1'b0, 16'h2603, 8'h00, 16'h0000, 16'h0000, 1'b1);
    obj(1'b1, 16'h2601, 8'h00, 16'hffff, 16'h0000, 1'b1);
    obj(1'b0, 16'h2601, 8'h00, 16'h0000, 16'h0000, 1'b0);
    fire(0, 7, 16'h2320, 1'b1);
    fire(0, 4, 16'h4210, 1'b1);
    fire(0, 9, 16'h8611, 1'b1);
    fire(0, 12, 16'h8a80, 1'b1);
    fire(0, 15, 16'h6310, 1'b1);
    fire(0, 3, 16'h7330, 1'b1);
    fire(0, 14, 16'h7331, 1'b1);
    fire(0, 10, 16'h5112, 1'b0);
    fire(1, 0, 16'h5210, 1'b1);
    fire(1, 1, 16'h6010, 1'b1);
    fire(1, 8, 16'h5443, 1'b1);
    fire(1, 9, 16'h5442, 1'b0);
    fire(1, 10, 16'h5441, 1'b0);
    fire(1, 12, 16'h8100, 1'b1);
    ctl.limit_mode = 16'h0001;
    quiet(16'h0600, 16'h0000);
    ctl.limit_mode = 16'h0000;
    ctl.link_mode = 16'h0000;
    quiet(16'h1000, 16'h0000);
    ctl.link_mode = 16'h0001;
    fire(2, 3, 16'h6321, 1'b0);
    fire(2, 12, 16'h81ff, 1'b0);
    obj(1'b1, 16'h2605, 8'h01, 16'hff7f, 16'h0000, 1'b0);
    quiet(16'h0000, 16'h0080);
    obj(1'b1, 16'h2605, 8'h01, 16'hffff, 16'h0000, 1'b0);
    obj(1'b1, 16'h2605, 8'h04, 16'hfffe, 16'h0000, 1'b0);
    quiet(16'h0001, 16'h0000);
    obj(1'b1, 16'h2605, 8'h04, 16'hffff, 16'h0000, 1'b0);
    ctl.stage_en = 1'b0;
    ctl.stage_enabling = 1'b1;
    fire(1, 8, 16'h5443, 1'b0);
    ctl.stage_enabling = 1'b0;
    fire(0, 4, 16'h4210, 1'b0);
    fire(1, 0, 16'h5210, 1'b1);
    obj(1'b1, 16'h2605, 8'h03, 16'h0010, 16'h0000, 1'b0);
    fire(0, 4, 16'h4210, 1'b1);
    obj(1'b1, 16'h2605, 8'h06, 16'h0000, 16'h0000, 1'b0);
    fire(1, 1, 16'h6010, 1'b0);
    ctl.stage_en = 1'b1;
    obj(1'b1, 16'h2605, 8'h02, 16'hff7f, 16'h0000, 1'b0);
    fire(0, 7, 16'h2320, 1'b0);
    obj(1'b1, 16'h2605, 8'h05, 16'hfffe, 16'h0000, 1'b0);
    fire(1, 0, 16'h5210, 1'b0);
    obj(1'b0, 16'h2605, 8'h02, 16'h0000, 16'hff7f, 1'b0);
    obj(1'b0, 16'h2604, 8'h00, 16'h0000, 16'h0008, 1'b0);
    det.sec = 16'h0002;
    det.ext = 16'h1000;
    @(negedge clk);
    obj(1'b0, 16'h2602, 8'h00, 16'h0000, 16'h0002, 1'b0);
    obj(1'b0, 16'h2605, 8'h07, 16'h0000, 16'h1000, 1'b0);
    obj(1'b1, 16'h2605, 8'h07, 16'h0000, 16'h0000, 1'b1);
    det = '0;
    rst_n = 1'b0;
    @(negedge clk);
    chk(hist_count, 8'h00);
    chk(ext_word, 16'h0000);
    rst_n = 1'b1;
    obj(1'b0, 16'h2605, 8'h02, 16'h0000, 16'hfbff, 1'b0);
    obj(1'b0, 16'h2605, 8'h05, 16'h0000, 16'hf1ff, 1'b0);
    conclude();
  end
endmodule

`default_nettype wire
